// File: rtl/bpbc_map.svh
// Constant map of the blanking, power-save and brightness control block.
// Assumes it is included by bare name from the design file.
`ifndef BPBC_MAP_SVH
`define BPBC_MAP_SVH

// Reset images of the global control and blanking-source control bytes.
`define BPBC_GCTL_RST     8'h00
`define BPBC_VCFG_RST     8'h04

// Global control byte: field positions.
`define BPBC_GCTL_BLANK   0
`define BPBC_GCTL_OFF     1
`define BPBC_GCTL_HALF    3
`define BPBC_GCTL_ADD     4

// Blanking-source control byte: field positions.
`define BPBC_VCFG_OOR     0
`define BPBC_VCFG_VBLEN   1
`define BPBC_VCFG_SCSEL   2
`define BPBC_VCFG_CLMP    3

// Reset values of the contrast and converter codes.
`define BPBC_CONTRAST_RST 7'h60
`define BPBC_CONV_RST     8'h80

`endif

// File: rtl/bpbc_pkg.sv
// Types shared by the blanking, power-save and brightness control block.
// Assumes nothing of its surroundings; holds types only.
package bpbc_pkg;

    // Decoded global control byte.
    typedef struct packed {
        logic half_range;   // Bias converters limited to half range.
        logic add_bright;   // Half of brightness added to each bias converter.
        logic out_off;      // Video output stage switched off.
        logic blank_all;    // Video fully blanked.
    } bpbc_gctl_t;

    // Decoded blanking-source control byte.
    typedef struct packed {
        logic clmp;         // Clamp option bit, stored only.
        logic sc_sel;       // One: sandcastle on clamp pin; zero: logic pulse.
        logic vbl_en;       // Vertical blanking enable.
        logic oor;          // Low option bit, stored only.
    } bpbc_vcfg_t;

    // Vertical retrace tracker.
    typedef enum logic [0:0] {
        BPBC_SCAN    = 1'b0,
        BPBC_RETRACE = 1'b1
    } bpbc_state_t;

endpackage

// File: rtl/bpbc_ctrl.sv
// Control decode for a video pre-amplifier: blanking source, power save,
// brightness mixing into the bias converters and retrace-aligned updates.
// Assumes host bytes arrive as single-cycle write strobes synchronous to clk_sys.
//
// Overview of operation
// (RL1) Select bit low: blanking from shared pin
// (RL2) Select bit high: sandcastle on clamp pin
// (RL3) Host sets blanking enable with sandcastle mode
// (RL4) Sandcastle mode: brightness drives shared pin too
// (RL5) Global bit 0 blanks video completely
// (RL6) Global bit 1 switches output stage off
// (RL7) Host sets both bits for deepest save
// (RL8) Global bit 3 halves bias converter range
// (RL9) Global bit 4 adds half brightness
// (RL10) Host sets bits 3 and 4 together
// (RL11) Three bias plus one brightness converter
// (RL12) Vertical blanking ORed with horizontal blanking
// (RL13) Contrast, brightness writes wait for retrace; code applies them at once while vbl_en is low
// (RL14) Mode bits registered, reset to defaults
`timescale 1ns/1ns
`include "bpbc_map.svh"

module bpbc_ctrl #(
    parameter int CONV_W = 8,    // Converter code width.
    parameter int CON_W  = 7     // Contrast code width.
) (
    // Clock, reset and clock enable.
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire logic                 clk_en,
    // Host configuration writes.
    input  wire logic                 gctl_wr,
    input  wire logic [7:0]           gctl_data,
    input  wire logic                 vcfg_wr,
    input  wire logic [7:0]           vcfg_data,
    input  wire logic                 contrast_wr,
    input  wire logic [CON_W-1:0]     contrast_data,
    input  wire logic                 bright_wr,
    input  wire logic [CONV_W-1:0]    bright_data,
    input  wire logic [2:0]           bias_wr,
    input  wire logic [CONV_W-1:0]    bias_data,
    // Timing inputs.
    input  wire logic                 hblank_in,
    input  wire logic                 shared_pin_in,
    input  wire logic                 clamp_vlvl,
    // Video control outputs.
    output logic                      blank_out,
    output logic                      vblank_out,
    output logic                      out_stage_off,
    output logic [CON_W-1:0]          contrast_out,
    // Converter outputs.
    output logic [CONV_W-1:0]         bright_out,
    output logic                      shared_pin_oe,
    output logic [CONV_W-1:0]         shared_pin_o,
    output logic [2:0][CONV_W-1:0]    bias_out,
    // Decoded configuration, for status.
    output bpbc_pkg::bpbc_gctl_t      gctl_out,
    output bpbc_pkg::bpbc_vcfg_t      vcfg_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks and decode functions.

    // The mixer halves codes, so a converter narrower than two bits is useless.
    if (CONV_W < 2 || CON_W < 2) begin : g_bad_width
        $error("bpbc_ctrl: code widths must be at least two bits.");
    end

    // Unpacks a global control byte into its fields.
    function automatic bpbc_pkg::bpbc_gctl_t dec_gctl(input logic [7:0] b);
        bpbc_pkg::bpbc_gctl_t g;
        g.half_range = b[`BPBC_GCTL_HALF];
        g.add_bright = b[`BPBC_GCTL_ADD];
        g.out_off    = b[`BPBC_GCTL_OFF];
        g.blank_all  = b[`BPBC_GCTL_BLANK];
        return g;
    endfunction

    // Unpacks a blanking-source control byte into its fields.
    function automatic bpbc_pkg::bpbc_vcfg_t dec_vcfg(input logic [7:0] b);
        bpbc_pkg::bpbc_vcfg_t v;
        v.clmp   = b[`BPBC_VCFG_CLMP];
        v.sc_sel = b[`BPBC_VCFG_SCSEL];
        v.vbl_en = b[`BPBC_VCFG_VBLEN];
        v.oor    = b[`BPBC_VCFG_OOR];
        return v;
    endfunction

    // Bias mixing: optional half range, optional half brightness added.
    // Saturates instead of wrapping, since a wrap would flash the screen dark.
    function automatic logic [CONV_W-1:0] bias_mix(input logic [CONV_W-1:0] code,
                                                   input logic [CONV_W-1:0] brt,
                                                   input logic half, input logic add);
        logic [CONV_W:0] sum;
        sum = {1'b0, half ? (code >> 1) : code} + {1'b0, add ? (brt >> 1) : {CONV_W{1'b0}}};
        return sum[CONV_W] ? '1 : sum[CONV_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and code registers.

    bpbc_pkg::bpbc_gctl_t     gctl_reg,  gctl_next;    // Global control.
    bpbc_pkg::bpbc_vcfg_t     vcfg_reg,  vcfg_next;    // Blanking source control.
    logic [CON_W-1:0]         con_reg,   con_next;     // Applied contrast.
    logic [CON_W-1:0]         conp_reg,  conp_next;    // Held contrast write.
    logic                     conf_reg,  conf_next;    // Contrast write pending.
    logic [CONV_W-1:0]        brt_reg,   brt_next;     // Applied brightness.
    logic [CONV_W-1:0]        brtp_reg,  brtp_next;    // Held brightness write.
    logic                     brtf_reg,  brtf_next;    // Brightness write pending.
    logic [2:0][CONV_W-1:0]   bias_reg,  bias_next;    // Bias converter codes.
    bpbc_pkg::bpbc_state_t    st_reg,    st_next;      // Retrace tracker.
    logic                     vsrc;                    // Selected vertical source.
    logic                     vb_act;                  // Vertical blanking active.
    logic                     apply;                   // Updates may take effect.

    // Source selection and the update window.
    always_comb begin
        vsrc   = vcfg_reg.sc_sel ? clamp_vlvl : shared_pin_in; // RL1 RL2
        // Sandcastle detection is only sound with the enable set by the host.
        vb_act = vcfg_reg.vbl_en & vsrc;                       // RL3
        // Without vertical blanking, writes land at once; else only in retrace.
        apply  = ~vcfg_reg.vbl_en | vb_act;                    // RL13
    end

    // Next values of configuration, held writes and the retrace tracker.
    always_comb begin
        gctl_next = gctl_reg;
        vcfg_next = vcfg_reg;
        con_next  = con_reg;
        conp_next = conp_reg;
        conf_next = conf_reg;
        brt_next  = brt_reg;
        brtp_next = brtp_reg;
        brtf_next = brtf_reg;
        bias_next = bias_reg;
        st_next   = vb_act ? bpbc_pkg::BPBC_RETRACE : bpbc_pkg::BPBC_SCAN;
        if (gctl_wr) begin
            gctl_next = dec_gctl(gctl_data);                   // RL14
        end
        if (vcfg_wr) begin
            vcfg_next = dec_vcfg(vcfg_data);                   // RL14
        end
        for (int i = 0; i < 3; i++) begin
            if (bias_wr[i]) begin
                bias_next[i] = bias_data;                      // RL11
            end
        end
        // A new write always replaces a held one; it is dropped only on a cycle with srst high or clk_en low.
        if (contrast_wr) begin
            conp_next = contrast_data;
            conf_next = 1'b1;
        end
        if (bright_wr) begin
            brtp_next = bright_data;
            brtf_next = 1'b1;
        end
        // Within the window, the newest value takes effect and the hold clears.
        if (apply) begin
            if (contrast_wr || conf_reg) begin
                con_next = contrast_wr ? contrast_data : conp_reg; // RL13
            end
            if (bright_wr || brtf_reg) begin
                brt_next = bright_wr ? bright_data : brtp_reg;     // RL13
            end
            conf_next = 1'b0;
            brtf_next = 1'b0;
        end
    end

    // Registers; reset wins over the clock enable.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gctl_reg <= dec_gctl(`BPBC_GCTL_RST);              // RL14
            vcfg_reg <= dec_vcfg(`BPBC_VCFG_RST);              // RL14
            con_reg  <= `BPBC_CONTRAST_RST;
            conp_reg <= `BPBC_CONTRAST_RST;
            conf_reg <= 1'b0;
            brt_reg  <= `BPBC_CONV_RST;
            brtp_reg <= `BPBC_CONV_RST;
            brtf_reg <= 1'b0;
            bias_reg <= {3{`BPBC_CONV_RST}};
            st_reg   <= bpbc_pkg::BPBC_SCAN;
        end else if (clk_en) begin
            gctl_reg <= gctl_next;
            vcfg_reg <= vcfg_next;
            con_reg  <= con_next;
            conp_reg <= conp_next;
            conf_reg <= conf_next;
            brt_reg  <= brt_next;
            brtp_reg <= brtp_next;
            brtf_reg <= brtf_next;
            bias_reg <= bias_next;
            st_reg   <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage: every output is a flip-flop, one cycle behind its source.

    logic [2:0][CONV_W-1:0]   bias_mix_next;               // Mixed bias codes.

    // One mixer per bias converter.
    for (genvar g = 0; g < 3; g++) begin : g_mix
        assign bias_mix_next[g] = bias_mix(bias_reg[g], brt_reg,
                                           gctl_reg.half_range,   // RL8
                                           gctl_reg.add_bright);  // RL9
    end

    // Registers the outputs; power-save blanking only forces blank_out high.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            blank_out     <= 1'b0;
            vblank_out    <= 1'b0;
            out_stage_off <= 1'b0;
            contrast_out  <= `BPBC_CONTRAST_RST;
            bright_out    <= `BPBC_CONV_RST;
            shared_pin_oe <= 1'b0;
            shared_pin_o  <= `BPBC_CONV_RST;
            bias_out      <= {3{`BPBC_CONV_RST}};
            gctl_out      <= dec_gctl(`BPBC_GCTL_RST);
            vcfg_out      <= dec_vcfg(`BPBC_VCFG_RST);
        end else if (clk_en) begin
            blank_out     <= gctl_reg.blank_all | hblank_in | vb_act; // RL5 RL12
            vblank_out    <= vb_act;                                  // RL12
            out_stage_off <= gctl_reg.out_off;                        // RL6
            contrast_out  <= con_reg;
            bright_out    <= brt_reg;                                 // RL11
            // The shared pin is an input in logic-pulse mode, so it is not driven.
            shared_pin_oe <= vcfg_reg.sc_sel;                         // RL1 RL4
            shared_pin_o  <= brt_reg;                                 // RL4
            bias_out      <= bias_mix_next;                           // RL8 RL9 RL11
            gctl_out      <= gctl_reg;
            vcfg_out      <= vcfg_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    a_pin_blank_src: assert property (@(posedge clk_sys) disable iff (srst) // RL1
        clk_en && !vcfg_reg.sc_sel && vcfg_reg.vbl_en && shared_pin_in |=> vblank_out)
        else $error("Shared-pin pulse did not raise vertical blanking.");

    a_sc_blank_src: assert property (@(posedge clk_sys) disable iff (srst) // RL2
        clk_en && vcfg_reg.sc_sel && vcfg_reg.vbl_en |=> vblank_out == $past(clamp_vlvl))
        else $error("Sandcastle source did not steer vertical blanking.");

    a_shared_drive: assert property (@(posedge clk_sys) disable iff (srst) // RL4
        clk_en |=> shared_pin_oe == $past(vcfg_reg.sc_sel)
                   && shared_pin_o == $past(brt_reg))
        else $error("Shared pin drive does not follow the source select.");

    a_power_blank: assert property (@(posedge clk_sys) disable iff (srst) // RL5
        clk_en && gctl_reg.blank_all |=> blank_out)
        else $error("Power-save blanking did not blank the video.");

    a_stage_off: assert property (@(posedge clk_sys) disable iff (srst) // RL6
        clk_en |=> out_stage_off == $past(gctl_reg.out_off))
        else $error("Output stage state does not follow global control.");

    a_half_range: assert property (@(posedge clk_sys) disable iff (srst) // RL8
        clk_en && gctl_reg.half_range && !gctl_reg.add_bright
        |=> bias_out[0] == ($past(bias_reg[0]) >> 1))
        else $error("Bias converter range was not halved.");

    a_add_bright: assert property (@(posedge clk_sys) disable iff (srst) // RL9
        clk_en && gctl_reg.add_bright && gctl_reg.half_range
        |=> bias_out[2] == ($past(bias_reg[2]) >> 1) + ($past(brt_reg) >> 1))
        else $error("Half brightness was not added to the bias converter.");

    a_hblank_or: assert property (@(posedge clk_sys) disable iff (srst) // RL12
        clk_en && hblank_in |=> blank_out)
        else $error("Horizontal blanking did not blank the video.");

    a_hold_write: assert property (@(posedge clk_sys) disable iff (srst) // RL13
        clk_en && vcfg_reg.vbl_en && !vb_act && bright_wr ##1 clk_en
        |=> bright_out == $past(bright_out))
        else $error("Brightness write took effect outside vertical retrace.");

    a_reset_dflt: assert property (@(posedge clk_sys) // RL14
        srst |=> vcfg_reg == dec_vcfg(`BPBC_VCFG_RST) && gctl_reg == dec_gctl(`BPBC_GCTL_RST))
        else $error("Mode bits did not return to their defaults.");

    c_sandcastle: cover property (@(posedge clk_sys) disable iff (srst)
        vcfg_reg.sc_sel && vb_act ##1 vblank_out);
    c_held_apply: cover property (@(posedge clk_sys) disable iff (srst)
        brtf_reg && vb_act && clk_en);
    c_cathode: cover property (@(posedge clk_sys) disable iff (srst)
        gctl_reg.half_range && gctl_reg.add_bright && clk_en);
    c_deep_save: cover property (@(posedge clk_sys) disable iff (srst)
        gctl_reg.blank_all && gctl_reg.out_off);
    c_retrace_in: cover property (@(posedge clk_sys) disable iff (srst)
        st_reg == bpbc_pkg::BPBC_SCAN && vb_act && clk_en);

endmodule

// File: dv/bpbc_host_model.sv
// Host model: the controller that writes configuration bytes into the block.
// Assumes the bench calls its tasks and that it shares clk_sys with the block.
`timescale 1ns/1ns

module bpbc_host_model (
    // Clock shared with the block.
    input  wire logic   clk_sys,
    // Write strobes and data towards the block.
    output logic        gctl_wr,
    output logic [7:0]  gctl_data,
    output logic        vcfg_wr,
    output logic [7:0]  vcfg_data,
    output logic        contrast_wr,
    output logic [6:0]  contrast_data,
    output logic        bright_wr,
    output logic [7:0]  bright_data,
    output logic [2:0]  bias_wr,
    output logic [7:0]  bias_data
);

//////////////////////////////////////////////////////////////////////////////
// All strobes start low so nothing is written before the first call.
initial begin
    {gctl_wr, vcfg_wr, contrast_wr, bright_wr, bias_wr} = 7'h00;
    {gctl_data, vcfg_data, contrast_data, bright_data, bias_data} = 39'h0;
end

// One write: kind 0 global, 1 source, 2 contrast, 3 brightness, 4..6 bias.
// Data is inverted on release so a stale byte never looks valid.
task automatic put(input logic [2:0] kind, input logic [7:0] d);
    @(posedge clk_sys);
    case (kind)
        3'h0: begin gctl_wr <= 1'h1; gctl_data <= d; end
        3'h1: begin vcfg_wr <= 1'h1; vcfg_data <= d; end
        3'h2: begin contrast_wr <= 1'h1; contrast_data <= d[6:0]; end
        3'h3: begin bright_wr <= 1'h1; bright_data <= d; end
        default: begin bias_wr <= 3'h1 << (kind - 3'h4); bias_data <= d; end
    endcase
    @(posedge clk_sys);
    {gctl_wr, vcfg_wr, contrast_wr, bright_wr, bias_wr} <= 7'h00;
    {gctl_data, vcfg_data, bright_data, bias_data} <= ~{d, d, d, d};
    contrast_data <= ~d[6:0];
endtask

// Sandcastle source always goes with the vertical enable bit.
task automatic set_sandcastle();
    put(3'h1, 8'h06);
endtask

// Deepest power save sets both save bits together.
task automatic deep_save();
    put(3'h0, 8'h03);
endtask

// Brightness at the cathodes sets half range and mixing together.
task automatic cathode_bright();
    put(3'h0, 8'h18);
endtask

endmodule

// File: dv/testbench.sv
// Self-checking bench for the blanking, power-save and brightness block.
// Assumes the host model drives the write ports and the bench the timing pins.
`timescale 1ns/1ns

module testbench;

logic                  clk_sys, srst, clk_en, hblank_in, shared_pin_in, clamp_vlvl;
logic                  gctl_wr, vcfg_wr, contrast_wr, bright_wr;
logic [7:0]            gctl_data, vcfg_data, bright_data, bias_data;
logic [6:0]            contrast_data, contrast_out;
logic [2:0]            bias_wr;
logic                  blank_out, vblank_out, out_stage_off, shared_pin_oe;
logic [7:0]            bright_out, shared_pin_o;
logic [2:0][7:0]       bias_out;
bpbc_pkg::bpbc_gctl_t  gctl_out;
bpbc_pkg::bpbc_vcfg_t  vcfg_out;
int                    n_mismatch, num_checks, cycles, i, j;
logic [7:0]            modes [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
logic [7:0]            codes [3] = '{8'h10, 8'hFF, 8'h81};
logic                  exp_v;

bpbc_ctrl u_bpbc_ctrl (.clk_sys, .srst, .clk_en, .gctl_wr, .gctl_data, .vcfg_wr,
    .vcfg_data, .contrast_wr, .contrast_data, .bright_wr, .bright_data, .bias_wr,
    .bias_data, .hblank_in, .shared_pin_in, .clamp_vlvl, .blank_out, .vblank_out,
    .out_stage_off, .contrast_out, .bright_out, .shared_pin_oe, .shared_pin_o,
    .bias_out, .gctl_out, .vcfg_out);

bpbc_host_model u_host (.clk_sys, .gctl_wr, .gctl_data, .vcfg_wr, .vcfg_data,
    .contrast_wr, .contrast_data, .bright_wr, .bright_data, .bias_wr, .bias_data);

//////////////////////////////////////////////////////////////////////////////
// Clock at 25 MHz, and a cycle ceiling so a hang still ends in the report.
initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
end

always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
        n_mismatch++;
        stop_test();
    end
end

//////////////////////////////////////////////////////////////////////////////
// Comparisons for flags and for codes, and the closing verdict.
task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask

task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask

task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0) begin
        $display("Regression OK");
    end else begin
        $display("Regression broken");
    end
    $finish;
endtask

// Covers the longest output path with margin, then samples mid-cycle.
task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
endtask

// Timing pins change just after a rising edge.
task automatic pins(input logic h, input logic s, input logic c);
    @(posedge clk_sys);
    hblank_in <= h;
    shared_pin_in <= s;
    clamp_vlvl <= c;
endtask

// Expected bias code: optional halving plus optional half brightness, saturated.
function automatic logic [7:0] mix(input logic [7:0] c, b, g);
    logic [8:0] s;
    s = (g[3] ? {2'h0, c[7:1]} : {1'h0, c}) + (g[4] ? {2'h0, b[7:1]} : 9'h000);
    return s[8] ? 8'hFF : s[7:0];
endfunction

// Every output but vblank_out and shared_pin_o at its power-on value; sandcastle source is the default.
task automatic chk_defaults();
    chk({1'h0, contrast_out}, 8'h60);
    chk(bright_out, 8'h80);
    for (j = 0; j < 3; j++) chk(bias_out[j], 8'h80);
    chk1(shared_pin_oe, 1'h1);
    chk({4'h0, vcfg_out}, 8'h04);
    chk({4'h0, gctl_out}, 8'h00);
    chk1(blank_out, 1'h0);
    chk1(out_stage_off, 1'h0);
endtask

//////////////////////////////////////////////////////////////////////////////
// Main sequence.
initial begin
    {srst, clk_en, hblank_in, shared_pin_in, clamp_vlvl} = 5'h18;
    repeat (3) @(posedge clk_sys);
    srst <= 1'h0;
    settle();
    chk_defaults();
    // Both power-save levels, alone and together.
    for (i = 1; i < 4; i++) begin
        if (i == 3) u_host.deep_save();
        else u_host.put(3'h0, i[7:0]);
        settle();
        chk1(blank_out, i[0]);
        chk1(out_stage_off, i[1]);
    end
    // Logic-pulse source: shared pin not driven, brightness still mixed.
    u_host.put(3'h1, 8'h00);
    u_host.put(3'h3, 8'hF0);
    for (j = 0; j < 3; j++) u_host.put(3'h4 + j[2:0], codes[j]);
    for (i = 0; i < 4; i++) begin
        if (i == 3) u_host.cathode_bright();
        else u_host.put(3'h0, modes[i]);
        settle();
        for (j = 0; j < 3; j++) chk(bias_out[j], mix(codes[j], 8'hF0, modes[i]));
    end
    chk({4'h0, gctl_out}, 8'h0C);
    chk1(shared_pin_oe, 1'h0);
    // Sandcastle source drives the brightness code onto the shared pin.
    u_host.set_sandcastle();
    settle();
    chk1(shared_pin_oe, 1'h1);
    chk(shared_pin_o, 8'hF0);
    chk({4'h0, vcfg_out}, 8'h06);
    // Vertical source follows the select bit, and blanks the video.
    for (i = 0; i < 2; i++) begin
        u_host.put(3'h1, i[0] ? 8'h06 : 8'h02);
        for (j = 0; j < 4; j++) begin
            pins(1'h0, j[0], j[1]);
            exp_v = i[0] ? j[1] : j[0];
            settle();
            chk1(vblank_out, exp_v);
            chk1(blank_out, exp_v);
        end
    end
    pins(1'h1, 1'h0, 1'h0);
    settle();
    chk1(blank_out, 1'h1);
    // Contrast and brightness writes wait for the retrace, newest wins.
    pins(1'h0, 1'h0, 1'h0);
    u_host.put(3'h3, 8'h33);
    u_host.put(3'h3, 8'h44);
    u_host.put(3'h2, 8'h11);
    settle();
    chk(bright_out, 8'hF0);
    chk({1'h0, contrast_out}, 8'h60);
    pins(1'h0, 1'h0, 1'h1);
    settle();
    chk(bright_out, 8'h44);
    chk({1'h0, contrast_out}, 8'h11);
    chk(shared_pin_o, 8'h44);
    u_host.put(3'h3, 8'h55);
    settle();
    chk(bright_out, 8'h55);
    // A write while the clock enable is low is not taken.
    pins(1'h0, 1'h0, 1'h0);
    // Let the dropped clamp level reach blank_out before freezing.
    @(posedge clk_sys);
    clk_en <= 1'h0;
    u_host.put(3'h0, 8'h01);
    settle();
    chk1(blank_out, 1'h0);
    @(posedge clk_sys);
    clk_en <= 1'h1;
    // A reset in mid-run restores every default.
    @(posedge clk_sys);
    srst <= 1'h1;
    @(posedge clk_sys);
    srst <= 1'h0;
    settle();
    chk_defaults();
    stop_test();
end

endmodule
